// ==== src/scgp_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module scgp_top #(
  parameter int CYC_PER_US = scgp_pkg::CLK_MHZ
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic program_rewrite_pin,
  output logic [1:0] pulse_output_pin,
  output logic channel0_busy_flag,
  output logic channel1_busy_flag,
  output logic sticky_error_flag,
  output logic momentary_error_flag,
  output logic irq
);
  import scgp_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic trig_ff, sticky_ff, mom_ff, err_prev_ff, run_ch_ff, irq_ff, wait_ff;
  logic [7:0] sel_ff, code_ff;
  logic [15:0] duty_ff;
  logic [IRQ_W-1:0] irq_stat_ff, irq_en_ff;
  logic [1:0] busy_prev_ff;
  logic [31:0] rdata_ff;
  logic nxt_trig, nxt_sticky, nxt_mom, nxt_err_prev, nxt_run_ch, nxt_irq, nxt_wait;
  logic [7:0] nxt_sel, nxt_code;
  logic [15:0] nxt_duty;
  logic [IRQ_W-1:0] nxt_irq_stat, nxt_irq_en, ev;
  logic [1:0] nxt_busy_prev;
  logic [31:0] nxt_rdata;

  logic halt_w, sel_ok, code_good, duty_good, err_now, wr_go, rd_go, start_any;
  logic [1:0] busy_w, pin_w, start_w;
  logic [TICK_W-1:0] tick_w;

  scgp_chan_if ch_if[2] ();

  // ----------------------------------------
  // Rewrite pin and channels
  // ----------------------------------------
  scgp_sync u_rewrite_sync (
    .clk(clk),
    .reset_n(reset_n),
    .din(program_rewrite_pin),
    .dout(halt_w)
  );

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ch
      assign ch_if[gi].start = start_w[gi];
      // A halted or dropped trigger stops both channels; a busy channel runs only while run_ch_ff names it
      assign ch_if[gi].run = trig_ff && !halt_w && (busy_w[gi] ? (run_ch_ff == 1'(gi)) : start_w[gi]);
      assign ch_if[gi].duty_ok = duty_good;
      assign ch_if[gi].tick_cyc = tick_w;
      assign ch_if[gi].duty = duty_ff[9:0];
      assign busy_w[gi] = ch_if[gi].busy;
      assign pin_w[gi] = ch_if[gi].pin;
      scgp_pwm_chan u_ch (
        .clk(clk),
        .reset_n(reset_n),
        .bus(ch_if[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // Checks and start decision
  // ----------------------------------------
  assign sel_ok = sel_ff <= SEL_MAX;
  assign code_good = code_ok(code_ff);
  assign duty_good = duty_ff < 16'(DUTY_SLOTS);
  // Tick is one thousandth of the period; integer scaling keeps every printed period exact when CYC_PER_US is a multiple of 4
  assign tick_w = TICK_W'(period_us(code_ff) * CYC_PER_US / DUTY_SLOTS);
  assign err_now = trig_ff && !halt_w && !(sel_ok && code_good && duty_good);
  assign start_any = trig_ff && !halt_w && sel_ok && code_good && duty_good && !(|busy_w);
  // Channel picked by the selector, only when both busy flags are clear
  assign start_w[0] = start_any && (sel_ff[0] == 1'b0);
  assign start_w[1] = start_any && (sel_ff[0] == 1'b1);
  assign wr_go = avs_write && !wait_ff;
  assign rd_go = avs_read && wait_ff;

  // ----------------------------------------
  // Registers, flags and bus slave
  // ----------------------------------------
  always_comb begin
    nxt_trig = trig_ff;
    nxt_sel = sel_ff;
    nxt_code = code_ff;
    nxt_duty = duty_ff;
    nxt_irq_en = irq_en_ff;
    nxt_sticky = sticky_ff;
    nxt_irq_stat = irq_stat_ff;
    nxt_run_ch = start_w[1] ? 1'b1 : (start_w[0] ? 1'b0 : run_ch_ff);
    nxt_err_prev = err_now;
    nxt_busy_prev = busy_w;
    nxt_rdata = rdata_ff;
    // One wait cycle, then a one-cycle answer
    nxt_wait = !((avs_read || avs_write) && wait_ff);
    ev = '0;
    ev[IRQ_ERR] = err_now && !err_prev_ff;
    ev[IRQ_START] = start_any;
    ev[IRQ_STOP] = |(busy_prev_ff & ~busy_w);
    if (wr_go) begin
      case (avs_address)
        OFS_CTRL: nxt_trig = avs_writedata[CTRL_TRIG];
        OFS_SEL: nxt_sel = avs_writedata[7:0];
        OFS_CODE: nxt_code = avs_writedata[7:0];
        OFS_DUTY: nxt_duty = avs_writedata[15:0];
        OFS_IRQ_EN: nxt_irq_en = avs_writedata[IRQ_W-1:0];
        OFS_IRQ_CLR: nxt_irq_stat = irq_stat_ff & ~avs_writedata[IRQ_W-1:0];
        OFS_ERR_CLR: nxt_sticky = sticky_ff && !avs_writedata[0];
        default: nxt_trig = trig_ff;
      endcase
    end
    // Set wins over a clear in the same cycle
    nxt_irq_stat = nxt_irq_stat | ev;
    nxt_sticky = nxt_sticky || err_now;
    nxt_mom = err_now && !err_prev_ff;
    nxt_irq = |(nxt_irq_stat & nxt_irq_en);
    if (rd_go) begin
      nxt_rdata = '0;
      case (avs_address)
        OFS_CTRL: nxt_rdata[CTRL_TRIG] = trig_ff;
        OFS_SEL: nxt_rdata[7:0] = sel_ff;
        OFS_CODE: nxt_rdata[7:0] = code_ff;
        OFS_DUTY: nxt_rdata[15:0] = duty_ff;
        OFS_STATUS: begin
          nxt_rdata[STAT_BUSY0] = busy_w[0];
          nxt_rdata[STAT_BUSY1] = busy_w[1];
          nxt_rdata[STAT_STICKY] = sticky_ff;
          nxt_rdata[STAT_HALT] = halt_w;
        end
        OFS_IRQ_STAT: nxt_rdata[IRQ_W-1:0] = irq_stat_ff;
        OFS_IRQ_EN: nxt_rdata[IRQ_W-1:0] = irq_en_ff;
        default: nxt_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      trig_ff <= 1'b0;
      sel_ff <= SEL_RST;
      code_ff <= CODE_RST;
      duty_ff <= DUTY_RST;
      irq_en_ff <= IRQ_EN_RST;
      irq_stat_ff <= '0;
      sticky_ff <= 1'b0;
      mom_ff <= 1'b0;
      err_prev_ff <= 1'b0;
      run_ch_ff <= 1'b0;
      busy_prev_ff <= 2'h0;
      irq_ff <= 1'b0;
      wait_ff <= 1'b1;
      rdata_ff <= 32'h00000000;
    end else begin
      trig_ff <= nxt_trig;
      sel_ff <= nxt_sel;
      code_ff <= nxt_code;
      duty_ff <= nxt_duty;
      irq_en_ff <= nxt_irq_en;
      irq_stat_ff <= nxt_irq_stat;
      sticky_ff <= nxt_sticky;
      mom_ff <= nxt_mom;
      err_prev_ff <= nxt_err_prev;
      run_ch_ff <= nxt_run_ch;
      busy_prev_ff <= nxt_busy_prev;
      irq_ff <= nxt_irq;
      wait_ff <= nxt_wait;
      rdata_ff <= nxt_rdata;
    end
  end

  assign avs_readdata = rdata_ff;
  assign avs_waitrequest = wait_ff;
  assign pulse_output_pin = pin_w;
  assign channel0_busy_flag = busy_w[0];
  assign channel1_busy_flag = busy_w[1];
  assign sticky_error_flag = sticky_ff;
  assign momentary_error_flag = mom_ff;
  assign irq = irq_ff;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  chk_start_gated: assert property (@(posedge clk) disable iff (!reset_n)
    |start_w |-> trig_ff && !halt_w && !(|busy_w))
    else $error("start while busy or off");

  chk_sel_error: assert property (@(posedge clk) disable iff (!reset_n)
    trig_ff && !halt_w && (sel_ff > SEL_MAX) |=> sticky_error_flag)
    else $error("bad selector not flagged");

  chk_code_error: assert property (@(posedge clk) disable iff (!reset_n)
    trig_ff && !halt_w && !code_ok(code_ff) |-> start_w == 2'h0 ##1 sticky_error_flag)
    else $error("bad period code started");

  chk_duty_error: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(trig_ff && !halt_w && duty_ff >= 16'(DUTY_SLOTS)) && !err_prev_ff |=> momentary_error_flag ##1 !momentary_error_flag)
    else $error("full duty not flagged");

  chk_halt_stops: assert property (@(posedge clk) disable iff (!reset_n)
    halt_w |=> busy_w == 2'h0 && pulse_output_pin == 2'h0)
    else $error("output during rewrite");

  chk_fast_tick: assert property (@(posedge clk) disable iff (!reset_n)
    start_any && code_ff == CODE_FAST_MIN |-> tick_w == TICK_W'(CYC_PER_US))
    else $error("wrong 1 ms tick");

  chk_slow_tick: assert property (@(posedge clk) disable iff (!reset_n)
    start_any && code_ff == 8'h00 |-> tick_w == TICK_W'(26 * CYC_PER_US))
    else $error("wrong 26 ms tick");

  chk_pin_busy: assert property (@(posedge clk) disable iff (!reset_n)
    pulse_output_pin[1] |-> channel1_busy_flag)
    else $error("pin without busy");

  chk_one_channel: assert property (@(posedge clk) disable iff (!reset_n)
    busy_w != 2'h3)
    else $error("both channels busy");

  chk_busy0_rise: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(busy_w[0]) |-> $past(start_w[0]))
    else $error("busy0 rose without start");

  chk_busy1_rise: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(busy_w[1]) |-> $past(start_w[1]))
    else $error("busy1 rose without start");

  chk_trig_off: assert property (@(posedge clk) disable iff (!reset_n)
    !trig_ff |=> busy_w == 2'h0)
    else $error("busy after trigger off");

  chk_keep_running: assert property (@(posedge clk) disable iff (!reset_n)
    busy_w[0] && trig_ff && !halt_w && !run_ch_ff |=> busy_w[0])
    else $error("channel 0 stopped with trigger on");

  chk_route_zero: assert property (@(posedge clk) disable iff (!reset_n)
    start_any && sel_ff == 8'h00 |=> busy_w == 2'h1)
    else $error("selector 0 not routed");

  chk_route_one: assert property (@(posedge clk) disable iff (!reset_n)
    start_any && sel_ff == 8'h01 |=> busy_w == 2'h2)
    else $error("selector 1 not routed");

  chk_sel_no_start: assert property (@(posedge clk) disable iff (!reset_n)
    sel_ff > SEL_MAX |-> start_w == 2'h0)
    else $error("start with bad selector");

  chk_halt_no_start: assert property (@(posedge clk) disable iff (!reset_n)
    halt_w |-> start_w == 2'h0)
    else $error("start during rewrite");

  chk_full_duty: assert property (@(posedge clk) disable iff (!reset_n)
    duty_ff >= 16'(DUTY_SLOTS) |-> start_w == 2'h0)
    else $error("start with full duty");

  chk_mom_pulse: assert property (@(posedge clk) disable iff (!reset_n)
    momentary_error_flag |=> !momentary_error_flag)
    else $error("momentary error longer than one cycle");

  chk_mom_sticky: assert property (@(posedge clk) disable iff (!reset_n)
    momentary_error_flag |-> sticky_error_flag)
    else $error("momentary error without sticky");

  chk_sticky_held: assert property (@(posedge clk) disable iff (!reset_n)
    sticky_error_flag && !(wr_go && avs_address == OFS_ERR_CLR) |=> sticky_error_flag)
    else $error("sticky error lost");

  chk_code_pulse: assert property (@(posedge clk) disable iff (!reset_n)
    trig_ff && !halt_w && !code_ok(code_ff) && !err_prev_ff |=> momentary_error_flag)
    else $error("bad code without momentary error");

  chk_idle_pins: assert property (@(posedge clk) disable iff (!reset_n)
    busy_w == 2'h0 |-> pulse_output_pin == 2'h0)
    else $error("pin high while idle");

  chk_start_event: assert property (@(posedge clk) disable iff (!reset_n)
    start_any |=> irq_stat_ff[IRQ_START])
    else $error("start event lost");

  chk_stop_event: assert property (@(posedge clk) disable iff (!reset_n)
    $fell(busy_w[0]) || $fell(busy_w[1]) |=> irq_stat_ff[IRQ_STOP])
    else $error("stop event lost");

  chk_irq_level: assert property (@(posedge clk) disable iff (!reset_n)
    irq == (|(irq_stat_ff & irq_en_ff)))
    else $error("irq level wrong");

  chk_wait_one: assert property (@(posedge clk) disable iff (!reset_n)
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");

  chk_wait_answer: assert property (@(posedge clk) disable iff (!reset_n)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered");

  chk_unmapped_read: assert property (@(posedge clk) disable iff (!reset_n)
    rd_go && (avs_address > OFS_ERR_CLR) |=> avs_readdata == 32'h00000000)
    else $error("unmapped read not zero");

  chk_code_lands: assert property (@(posedge clk) disable iff (!reset_n)
    wr_go && avs_address == OFS_CODE |=> code_ff == $past(avs_writedata[7:0]))
    else $error("code write lost");
endmodule // scgp_top
`default_nettype wire

// ==== src/scgp_pkg.sv ====
// Function
// - Start output only when the channel is not busy and the trigger is on.
// - Keep generating while the trigger stays on, stop when it drops.
// - Duty is accepted at any time; period is latched only at start.
// - Codes 16#11..16#16 give 1.0, 1.25, 2.0, 2.5, 5.0, 10 ms periods.
// - Codes 16#0..16#8 give 26 ms up to 6.7 s periods in order.
// - Drive the output picked by the selector; only 0 and 1 are valid.
// - An invalid selector sets the sticky error and pulses the momentary error.
// - An unsupported period code raises both errors and does not start.
// - Duty of 100 percent or more raises both errors.
// - Each channel has its own busy flag showing the output in use.
// - Near minimum and maximum duty the real on ratio may differ.
// - While the program is rewritten during run, generation halts.
// - A duty change takes effect only once the running period completes.
package scgp_pkg;

  localparam int CLK_MHZ = 40;
  localparam int TICK_W = 24;
  localparam int DUTY_SLOTS = 1000;
  localparam logic [9:0] DUTY_LAST = 10'(DUTY_SLOTS - 1);

  // Period lengths in microseconds
  localparam int PER_US_H11 = 1000;
  localparam int PER_US_H12 = 1250;
  localparam int PER_US_H13 = 2000;
  localparam int PER_US_H14 = 2500;
  localparam int PER_US_H15 = 5000;
  localparam int PER_US_H16 = 10000;
  localparam int PER_US_H0 = 26000;
  localparam int PER_US_H1 = 52000;
  localparam int PER_US_H2 = 105000;
  localparam int PER_US_H3 = 210000;
  localparam int PER_US_H4 = 420000;
  localparam int PER_US_H5 = 840000;
  localparam int PER_US_H6 = 1600000;
  localparam int PER_US_H7 = 3400000;
  localparam int PER_US_H8 = 6700000;

  localparam logic [7:0] CODE_SLOW_MAX = 8'h08;
  localparam logic [7:0] CODE_FAST_MIN = 8'h11;
  localparam logic [7:0] CODE_FAST_MAX = 8'h16;
  localparam logic [7:0] SEL_MAX = 8'h01;

  // Register byte offsets
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_SEL = 6'h04;
  localparam logic [5:0] OFS_CODE = 6'h08;
  localparam logic [5:0] OFS_DUTY = 6'h0C;
  localparam logic [5:0] OFS_STATUS = 6'h10;
  localparam logic [5:0] OFS_IRQ_STAT = 6'h14;
  localparam logic [5:0] OFS_IRQ_EN = 6'h18;
  localparam logic [5:0] OFS_IRQ_CLR = 6'h1C;
  localparam logic [5:0] OFS_ERR_CLR = 6'h20;

  // Field positions
  localparam int CTRL_TRIG = 0;
  localparam int STAT_BUSY0 = 0;
  localparam int STAT_BUSY1 = 1;
  localparam int STAT_STICKY = 2;
  localparam int STAT_HALT = 3;
  localparam int IRQ_ERR = 0;
  localparam int IRQ_START = 1;
  localparam int IRQ_STOP = 2;
  localparam int IRQ_W = 3;

  // Values after reset
  localparam logic [7:0] SEL_RST = 8'h00;
  localparam logic [7:0] CODE_RST = 8'h00;
  localparam logic [15:0] DUTY_RST = 16'h0000;
  localparam logic [IRQ_W-1:0] IRQ_EN_RST = 3'h0;

  function automatic logic code_ok(input logic [7:0] c);
    return (c <= CODE_SLOW_MAX) || ((c >= CODE_FAST_MIN) && (c <= CODE_FAST_MAX));
  endfunction

  function automatic int period_us(input logic [7:0] c);
    case (c)
      8'h00: return PER_US_H0;
      8'h01: return PER_US_H1;
      8'h02: return PER_US_H2;
      8'h03: return PER_US_H3;
      8'h04: return PER_US_H4;
      8'h05: return PER_US_H5;
      8'h06: return PER_US_H6;
      8'h07: return PER_US_H7;
      8'h08: return PER_US_H8;
      8'h11: return PER_US_H11;
      8'h12: return PER_US_H12;
      8'h13: return PER_US_H13;
      8'h14: return PER_US_H14;
      8'h15: return PER_US_H15;
      8'h16: return PER_US_H16;
      default: return 0;
    endcase
  endfunction

endpackage

// ==== src/scgp_chan_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface scgp_chan_if;
  logic start;
  logic run;
  logic duty_ok;
  logic [scgp_pkg::TICK_W-1:0] tick_cyc;
  logic [9:0] duty;
  logic pin;
  logic busy;
  modport ctl (output start, run, duty_ok, tick_cyc, duty, input pin, busy);
  modport gen (input start, run, duty_ok, tick_cyc, duty, output pin, busy);
endinterface
`default_nettype wire

// ==== src/scgp_sync.sv ====
`timescale 1ns/100ps
`default_nettype none
module scgp_sync (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic din,
  output logic dout
);
  logic s1_ff, s2_ff, s3_ff, lvl_ff;
  logic nxt_lvl;

  // Level only moves once the two later stages agree
  always_comb begin
    nxt_lvl = (s2_ff == s3_ff) ? s3_ff : lvl_ff;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      lvl_ff <= 1'b0;
    end else begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      lvl_ff <= nxt_lvl;
    end
  end

  assign dout = lvl_ff;
endmodule // scgp_sync
`default_nettype wire

// ==== src/scgp_pwm_chan.sv ====
`timescale 1ns/100ps
`default_nettype none
module scgp_pwm_chan (
  input wire logic clk,
  input wire logic reset_n,
  scgp_chan_if.gen bus
);
  import scgp_pkg::*;

  logic active_ff, pin_ff;
  logic [TICK_W-1:0] tick_ff, pre_ff;
  logic [9:0] slot_ff, duty_ff;
  logic nxt_active, nxt_pin;
  logic [TICK_W-1:0] nxt_tick, nxt_pre;
  logic [9:0] nxt_slot, nxt_duty;

  // ----------------------------------------
  // Period and slot counting
  // ----------------------------------------
  always_comb begin
    nxt_active = active_ff;
    nxt_tick = tick_ff;
    nxt_pre = pre_ff;
    nxt_slot = slot_ff;
    nxt_duty = duty_ff;
    if (!bus.run) begin
      nxt_active = 1'b0;
      nxt_pre = '0;
      nxt_slot = '0;
    end else if (bus.start && !active_ff) begin
      nxt_active = 1'b1;
      nxt_tick = bus.tick_cyc;
      nxt_pre = '0;
      nxt_slot = '0;
      nxt_duty = bus.duty;
    end else if (active_ff) begin
      if (pre_ff >= tick_ff - TICK_W'(1)) begin
        nxt_pre = '0;
        if (slot_ff == DUTY_LAST) begin
          nxt_slot = '0;
          // New duty only at a period boundary
          if (bus.duty_ok) begin
            nxt_duty = bus.duty;
          end
        end else begin
          nxt_slot = slot_ff + 10'h001;
        end
      end else begin
        nxt_pre = pre_ff + TICK_W'(1);
      end
    end
    // Registered pin is built from the next slot and duty, so it lines up with the slot at every duty
    nxt_pin = nxt_active && (nxt_slot < nxt_duty);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      active_ff <= 1'b0;
      pin_ff <= 1'b0;
      tick_ff <= '0;
      pre_ff <= '0;
      slot_ff <= '0;
      duty_ff <= '0;
    end else begin
      active_ff <= nxt_active;
      pin_ff <= nxt_pin;
      tick_ff <= nxt_tick;
      pre_ff <= nxt_pre;
      slot_ff <= nxt_slot;
      duty_ff <= nxt_duty;
    end
  end

  assign bus.pin = pin_ff;
  assign bus.busy = active_ff;

  chk_idle_pin_low: assert property (@(posedge clk) disable iff (!reset_n)
    !active_ff |-> !pin_ff) else $error("pin high while idle");
  chk_stop_on_drop: assert property (@(posedge clk) disable iff (!reset_n)
    !bus.run |=> !active_ff && !pin_ff) else $error("still running after trigger off");
  chk_duty_at_wrap: assert property (@(posedge clk) disable iff (!reset_n)
    active_ff && $past(active_ff) && (duty_ff != $past(duty_ff)) |-> slot_ff == 10'h000)
    else $error("duty changed mid period");
  chk_period_held: assert property (@(posedge clk) disable iff (!reset_n)
    active_ff && $past(active_ff) |-> tick_ff == $past(tick_ff))
    else $error("period changed while running");
endmodule // scgp_pwm_chan
`default_nettype wire

// ==== verification/scgp_scan_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Scan-side partner: rewrite source, pin meter
// ----------------------------------------
module scgp_scan_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic halt_req,
  input wire logic meas_clr,
  input wire logic [1:0] pulse_output_pin,
  output logic program_rewrite_pin,
  output int on0,
  output int on1
);
  // Fast counter of the channel is never claimed here
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      program_rewrite_pin <= 1'b0;
      on0 <= 0;
      on1 <= 0;
    end else begin
      program_rewrite_pin <= halt_req;
      // Clear keeps the current sample, so no slot of a period is lost
      on0 <= (meas_clr ? 0 : on0) + int'(pulse_output_pin[0]);
      on1 <= (meas_clr ? 0 : on1) + int'(pulse_output_pin[1]);
    end
  end
endmodule // scgp_scan_model
`default_nettype wire

// ==== verification/scan_gated_pwm_output_bench.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin mismatches++; $display("Error %s expected %0h seen %0h", n, e, g); end end
module scan_gated_pwm_output_bench;
  import scgp_pkg::*;
  // One cycle per us keeps a 16#11 period at 1000 cycles
  localparam int WIN = 1000;
  logic clk = 1'b0;
  logic reset_n, avs_read, avs_write, avs_waitrequest, halt_req, meas_clr, rew;
  logic busy0, busy1, sticky, moment, irq;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [1:0] pin;
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;
  int moms = 0;
  int on0, on1, d1, d2;
  int msk [int] = '{0: 1, 4: 'hFF, 8: 'hFF, 12: 'hFFFF, 24: 7};
  int shadow [int] = '{0: 0, 4: 0, 8: 0, 12: 0, 24: 0};
  logic [7:0] codes [15] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
                             8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16};

  always #12.5 clk = ~clk;

  scgp_top #(.CYC_PER_US(1)) dut_u (.clk(clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .program_rewrite_pin(rew),
    .pulse_output_pin(pin), .channel0_busy_flag(busy0), .channel1_busy_flag(busy1),
    .sticky_error_flag(sticky), .momentary_error_flag(moment), .irq(irq));

  scgp_scan_model part_u (.clk(clk), .reset_n(reset_n), .halt_req(halt_req), .meas_clr(meas_clr),
    .pulse_output_pin(pin), .program_rewrite_pin(rew), .on0(on0), .on1(on1));

  task automatic results();
    $display("Checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Run ceiling well above the few thousand cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (moment === 1'b1) moms++;
    if (cycles == 20000) begin
      `CHK("timeout", 0, cycles)
      results();
    end
  end

  // ----------------------------------------
  // Bus, model and measurement tasks
  // ----------------------------------------
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    if (msk.exists(int'(a))) shadow[int'(a)] = int'(d) & msk[int'(a)];
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    `CHK("readdata", e, q)
  endtask

  task automatic wait_busy(input int ch, input logic v);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while ((ch ? busy1 : busy0) !== v && n < 40);
    `CHK("busy", v, (ch ? busy1 : busy0))
  endtask

  task automatic meas();
    meas_clr <= 1'b1;
    @(posedge clk);
    meas_clr <= 1'b0;
    repeat (WIN - 1) @(posedge clk);
    #1;
  endtask

  task automatic err_case(input logic [7:0] s, input logic [7:0] c, input logic [15:0] d);
    int m;
    m = moms;
    wr(OFS_SEL, 32'(s));
    wr(OFS_CODE, 32'(c));
    wr(OFS_DUTY, 32'(d));
    wr(OFS_CTRL, 32'h1);
    repeat (4) @(posedge clk);
    #1;
    `CHK("sticky", 1'b1, sticky)
    `CHK("momentary", m + 1, moms)
    `CHK("no start", 2'b00, {busy1, busy0})
    rd_chk(OFS_STATUS, 32'h4);
    wr(OFS_CTRL, 32'h0);
    wr(OFS_ERR_CLR, 32'h1);
    @(posedge clk);
    #1;
    `CHK("sticky clear", 1'b0, sticky)
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    reset_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 6'h00;
    avs_writedata = 32'h0000_0000;
    halt_req = 1'b0;
    meas_clr = 1'b0;
    void'($urandom(40));
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    #1;
    `CHK("pins idle", 2'b00, pin)
    `CHK("busy idle", 2'b00, {busy1, busy0})
    foreach (shadow[a]) rd_chk(6'(a), 32'(shadow[a]));
    rd_chk(OFS_STATUS, 32'h0);
    wr(6'h24, 32'hFFFF_FFFF);
    rd_chk(6'h24, 32'h0);
    rd_chk(OFS_IRQ_CLR, 32'h0);
    wr(OFS_IRQ_CLR, 32'h7);
    // Every period code must start and stop cleanly
    wr(OFS_DUTY, 32'h1);
    foreach (codes[i]) begin
      wr(OFS_CODE, 32'(codes[i]));
      wr(OFS_CTRL, 32'h1);
      wait_busy(0, 1'b1);
      `CHK("no error", 1'b0, sticky)
      wr(OFS_CTRL, 32'h0);
      wait_busy(0, 1'b0);
      `CHK("pin off", 2'b00, pin)
    end
    err_case(8'h02, 8'h11, 16'h01F4);
    err_case(8'($urandom_range(255, 2)), 8'h11, 16'h01F4);
    err_case(8'h00, 8'h09, 16'h01F4);
    err_case(8'h00, 8'h10, 16'h01F4);
    err_case(8'h00, 8'($urandom_range(255, 23)), 16'h01F4);
    err_case(8'h00, 8'h11, 16'h03E8);
    err_case(8'h00, 8'h11, 16'($urandom_range(65535, 1000)));
    // Channel 1 run, duty and code changed inside the first period
    d1 = $urandom_range(998, 2);
    d2 = (d1 > 500) ? d1 - int'($urandom_range(400, 1)) : d1 + int'($urandom_range(400, 1));
    wr(OFS_SEL, 32'h1);
    wr(OFS_CODE, 32'h11);
    wr(OFS_DUTY, 32'(d1));
    wr(OFS_CTRL, 32'h1);
    wait_busy(1, 1'b1);
    fork
      meas();
      begin
        repeat (100) @(posedge clk);
        wr(OFS_DUTY, 32'(d2));
        wr(OFS_CODE, 32'h13);
      end
    join
    `CHK("on1 first", d1, on1)
    `CHK("on0 idle", 0, on0)
    meas();
    `CHK("on1 second", d2, on1)
    rd_chk(OFS_CODE, 32'h13);
    wr(OFS_SEL, 32'h0);
    repeat (3) @(posedge clk);
    #1;
    `CHK("busy0 held off", 1'b0, busy0)
    // Program rewrite halts output, restart follows once it ends
    halt_req <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
    `CHK("halt busy", 2'b00, {busy1, busy0})
    `CHK("halt pin", 2'b00, pin)
    rd_chk(OFS_STATUS, 32'h8);
    wr(OFS_CODE, 32'h11);
    halt_req <= 1'b0;
    wait_busy(0, 1'b1);
    meas();
    `CHK("on0 run", d2, on0)
    `CHK("on1 stopped", 0, on1)
    wr(OFS_CTRL, 32'h0);
    wait_busy(0, 1'b0);
    // Error interrupt raised, masked and cleared
    rd_chk(OFS_IRQ_STAT, 32'h7);
    wr(OFS_IRQ_CLR, 32'h7);
    wr(OFS_IRQ_EN, 32'h1);
    err_case(8'h03, 8'h11, 16'h01F4);
    `CHK("irq on", 1'b1, irq)
    rd_chk(OFS_IRQ_STAT, 32'h1);
    rd_chk(OFS_IRQ_EN, 32'(shadow[24]));
    wr(OFS_IRQ_EN, 32'h0);
    repeat (2) @(posedge clk);
    #1;
    `CHK("irq masked", 1'b0, irq)
    wr(OFS_IRQ_EN, 32'h1);
    wr(OFS_IRQ_CLR, 32'h1);
    repeat (2) @(posedge clk);
    #1;
    `CHK("irq cleared", 1'b0, irq)
    rd_chk(OFS_IRQ_STAT, 32'h0);
    results();
  end
endmodule // scan_gated_pwm_output_bench
`default_nettype wire
